// [sdram_pkg.sv]
// Shared constants, timings and command codes for the DRAM read path.
package sdram_pkg;
  localparam int BANKS     = 4;
  localparam int BANK_W    = 2;
  localparam int ROW_W     = 12;
  localparam int COL_W     = 9;
  localparam int DQ_W      = 16;
  localparam int ROW_PAT_W = DQ_W - BANK_W - COL_W;
  localparam int AUTO_BIT  = 10;
  localparam int TMR_W     = 4;
  localparam int LEFT_W    = 4;
  localparam int LAT_MIN   = 2;

  localparam int CLK_PERIOD_PS       = 10000;
  localparam int ACT_COL_DELAY_NS    = 20;
  localparam int SAME_BANK_ACT_NS    = 60;
  localparam int OTHER_BANK_ACT_NS   = 15;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ACT_COL_DELAY_CYC   = (ACT_COL_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SAME_BANK_ACT_CYC   = (SAME_BANK_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OTHER_BANK_ACT_CYC  = (OTHER_BANK_ACT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PRECHARGE_CYC       = (PRECHARGE_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_BURST_STOP
  } cmd_t;
endpackage

// [sdram_link_if.sv]
// Command, address, mask and data wires between the controller and the DRAM.
interface sdram_link_if;
  import sdram_pkg::*;
  cmd_t              cmd;
  logic [BANK_W-1:0] bank;
  logic [ROW_W-1:0]  addr;
  logic              mask;
  logic [DQ_W-1:0]   dq;
  logic              dq_oe;

  modport dev (input cmd, input bank, input addr, input mask, output dq, output dq_oe);
  modport ctl (output cmd, output bank, output addr, output mask, input dq, input dq_oe);
endinterface

// [sdram_device.sv]
// DRAM end: bank activation tracking, read bursts, truncation and mask-driven output control.
//
// Functional notes
// - Rows must be opened before column commands.
// - Column command waits activate-to-column delay.
// - Same-bank reactivation needs precharge and interval.
// - Other-bank activate allowed with spacing.
// - Read carries column; optional auto precharge.
// - First word after latency, then one per clock.
// - Pins released when the burst ends.
// - Page burst runs on, wrapping column zero.
// - Read truncates reads seamlessly, latency-minus-one early.
// - Reads accepted on every clock.
// - Write after read needs contention-free turnaround.
// - Mask suppresses output after two clocks.
// - Write forces pins off if mask preceded.
// - Mask low before write; zero input latency.
// - Precharge truncates fixed read, latency-minus-one early.
// - No bank command during precharge period.
// - Burst stop ends read, latency-minus-one early.
// - Read latency is two or three.
// - Drive from n+m-1, valid by n+m; the device raises dq_oe and the data together at n+m.
module sdram_device
  import sdram_pkg::*;
(
  input  wire logic                 SYS_CLK_IN,
  input  wire logic                 SYS_RST_IN,
  input  wire logic                 READ_LATENCY_IN,
  input  wire logic [2:0]           BURST_LENGTH_IN,
  output logic [sdram_pkg::BANKS-1:0] BANK_OPEN_OUT,
  output logic                      CMD_ERROR_OUT,
  sdram_link_if.dev                 lnk
);
  import sdram_pkg::*;

  typedef struct packed {
    logic                  v;
    logic [DQ_W-1:0]       d;
  } elem_t;

  typedef struct packed {
    logic [BANKS-1:0]            open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    logic                        run;
    logic [BANK_W-1:0]           bnk;
    logic [COL_W-1:0]            col;
    logic [COL_W-1:0]            wrap;
    logic [LEFT_W-1:0]           left;
    logic                        ap;
    logic                        cont;
    logic [1:0]                  pipe_v;
    logic [1:0][DQ_W-1:0]        pipe_d;
    logic                        mask;
    logic                        oe;
    logic [DQ_W-1:0]             dq;
    logic                        err;
  } dev_st_t;

  dev_st_t           s_q;
  dev_st_t           s_d;
  logic [BANK_W-1:0] b;
  logic [COL_W-1:0]  col0;
  logic [COL_W-1:0]  wrap0;
  logic [LEFT_W-1:0] len0;
  logic              cont0;
  logic              push;
  logic [DQ_W-1:0]   pdata;
  logic              hit;
  elem_t             src;

  // Read data carries its own bank, low row bits and column so a bench can check ordering.
  function automatic logic [DQ_W-1:0] word(input logic [BANK_W-1:0] bk,
                                           input logic [ROW_W-1:0]  rw,
                                           input logic [COL_W-1:0]  cl);
    word = {bk, rw[ROW_PAT_W-1:0], cl};
  endfunction

  // Fixed bursts wrap inside their aligned block; a page burst wraps the whole row.
  function automatic logic [COL_W-1:0] step(input logic [COL_W-1:0] cl,
                                            input logic [COL_W-1:0] wm);
    step = (cl & ~wm) | ((cl + COL_W'(1)) & wm);
  endfunction

  always_comb
  begin
    b     = lnk.bank;
    col0  = lnk.addr[COL_W-1:0];
    cont0 = (BURST_LENGTH_IN == BL_PAGE);
    if (cont0 || BURST_LENGTH_IN > BL_8)
    begin
      len0  = '0;
      wrap0 = '1;
    end
    else
    begin
      len0  = LEFT_W'(1) << BURST_LENGTH_IN[1:0];
      wrap0 = COL_W'(len0 - LEFT_W'(1));
    end
    hit = (lnk.addr[AUTO_BIT] || s_q.bnk == b);
  end

  always_comb
  begin
    s_d     = s_q;
    s_d.err = 1'b0;
    s_d.mask = lnk.mask;
    push    = 1'b0;
    pdata   = '0;
    if (s_q.run)
    begin
      push     = 1'b1;
      pdata    = word(s_q.bnk, s_q.row[s_q.bnk], s_q.col);
      s_d.col  = step(s_q.col, s_q.wrap);
      if (!s_q.cont)
      begin
        s_d.left = s_q.left - LEFT_W'(1);
        if (s_q.left == LEFT_W'(1))
        begin
          s_d.run = 1'b0;
          if (s_q.ap)
          begin
            s_d.open[s_q.bnk] = 1'b0;
          end
        end
      end
    end
    case (lnk.cmd)
      CMD_ACTIVE:
      begin
        if (s_q.open[b])
        begin
          s_d.err = 1'b1;
        end
        else
        begin
          s_d.open[b] = 1'b1;
          s_d.row[b]  = lnk.addr;
        end
      end
      CMD_READ:
      begin
        if (!s_q.open[b])
        begin
          s_d.err = 1'b1;
        end
        else
        begin
          // A new read replaces the running burst; words already in the pipe still leave.
          push      = 1'b1;
          pdata     = word(b, s_q.row[b], col0);
          s_d.bnk   = b;
          s_d.wrap  = wrap0;
          s_d.col   = step(col0, wrap0);
          s_d.cont  = cont0;
          s_d.ap    = lnk.addr[AUTO_BIT] && !cont0;
          s_d.left  = len0 - LEFT_W'(1);
          s_d.run   = cont0 || len0 > LEFT_W'(1);
          if (!s_d.run && s_d.ap)
          begin
            s_d.open[b] = 1'b0;
          end
        end
      end
      CMD_WRITE:
      begin
        s_d.run = 1'b0;
        push    = 1'b0;
        if (!s_q.open[b] || (!s_q.mask && (s_q.oe || s_q.pipe_v != 2'h0)))
        begin
          s_d.err = 1'b1;
        end
      end
      CMD_PRECHARGE:
      begin
        if (hit)
        begin
          s_d.run = 1'b0;
          push    = 1'b0;
        end
        if (lnk.addr[AUTO_BIT])
        begin
          s_d.open = '0;
        end
        else
        begin
          s_d.open[b] = 1'b0;
        end
      end
      CMD_BURST_STOP:
      begin
        s_d.run = 1'b0;
        push    = 1'b0;
      end
      default:
      begin
      end
    endcase
    s_d.pipe_v = {s_q.pipe_v[0], push};
    s_d.pipe_d = {s_q.pipe_d[0], pdata};
    // Stage 0 feeds latency two, stage 1 latency three; the output flop adds the last edge.
    src.v = READ_LATENCY_IN ? s_q.pipe_v[1] : s_q.pipe_v[0];
    src.d = READ_LATENCY_IN ? s_q.pipe_d[1] : s_q.pipe_d[0];
    s_d.oe = src.v && !s_q.mask;
    s_d.dq = src.d;
    if (lnk.cmd == CMD_WRITE)
    begin
      // Flushing here is what keeps late read words off a bus the writer now owns.
      s_d.pipe_v = 2'h0;
      s_d.oe     = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign BANK_OPEN_OUT = s_q.open;
  assign CMD_ERROR_OUT = s_q.err;
  assign lnk.dq        = s_q.dq;
  assign lnk.dq_oe     = s_q.oe;
endmodule

// [sdram_controller.sv]
// Controller end: opens rows, spaces commands and issues single-word reads into a two-entry buffer.
module sdram_controller
  import sdram_pkg::*;
#(
  parameter int READ_LATENCY = 2
)
(
  input  wire logic                        SYS_CLK_IN,
  input  wire logic                        SYS_RST_IN,
  input  wire logic                        REQ_VALID_IN,
  input  wire logic [sdram_pkg::BANK_W-1:0] REQ_BANK_IN,
  input  wire logic [sdram_pkg::ROW_W-1:0]  REQ_ROW_IN,
  input  wire logic [sdram_pkg::COL_W-1:0]  REQ_COL_IN,
  input  wire logic                        REQ_AUTO_PRE_IN,
  output logic                             REQ_ACCEPT_OUT,
  output logic                             RD_VALID_OUT,
  output logic [sdram_pkg::DQ_W-1:0]        RD_DATA_OUT,
  input  wire logic                        RD_READY_IN,
  sdram_link_if.ctl                        lnk
);
  import sdram_pkg::*;

  localparam logic [TMR_W-1:0] RCD_LD = TMR_W'(ACT_COL_DELAY_CYC - 1);
  localparam logic [TMR_W-1:0] RC_LD  = TMR_W'(SAME_BANK_ACT_CYC - 1);
  localparam logic [TMR_W-1:0] RRD_LD = TMR_W'(OTHER_BANK_ACT_CYC - 1);
  localparam logic [TMR_W-1:0] RP_LD  = TMR_W'(PRECHARGE_CYC - 1);
  localparam logic [TMR_W-1:0] AP_LD  = TMR_W'(PRECHARGE_CYC - 1 + READ_LATENCY);

  typedef struct packed {
    cmd_t                        cmd;
    logic [BANK_W-1:0]           bank;
    logic [ROW_W-1:0]            addr;
    logic                        mask;
    logic [BANKS-1:0]            open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    logic [BANKS-1:0][TMR_W-1:0] rcd;
    logic [BANKS-1:0][TMR_W-1:0] rc;
    logic [BANKS-1:0][TMR_W-1:0] rp;
    logic [TMR_W-1:0]            rrd;
    logic                        taken;
    logic [READ_LATENCY:0]       fly;
    logic [1:0][DQ_W-1:0]        buff;
    logic [1:0]                  cnt;
    logic                        vld;
  } ctl_st_t;

  ctl_st_t           s_q;
  ctl_st_t           s_d;
  logic [BANK_W-1:0] b;
  logic [1:0]        inflight;
  logic              room;
  logic              rd;
  logic              pop;
  logic              arrive;
  logic [1:0]        after_pop;

  always_comb
  begin
    s_d      = s_q;
    b        = REQ_BANK_IN;
    rd       = 1'b0;
    inflight = 2'h0;
    for (int i = 0; i <= READ_LATENCY; i++)
    begin
      inflight = inflight + 2'(s_q.fly[i]);
    end
    // Counting words still on the wire is what lets a stalled reader hold off new reads.
    room = (s_q.cnt + inflight) < 2'h2;
    for (int i = 0; i < BANKS; i++)
    begin
      if (s_q.rcd[i] != '0) s_d.rcd[i] = s_q.rcd[i] - TMR_W'(1);
      if (s_q.rc[i] != '0)  s_d.rc[i]  = s_q.rc[i] - TMR_W'(1);
      if (s_q.rp[i] != '0)  s_d.rp[i]  = s_q.rp[i] - TMR_W'(1);
    end
    if (s_q.rrd != '0)
    begin
      s_d.rrd = s_q.rrd - TMR_W'(1);
    end
    s_d.cmd   = CMD_NOP;
    s_d.taken = 1'b0;
    s_d.mask  = 1'b0;
    s_d.bank  = b;
    if (REQ_VALID_IN && !s_q.taken)
    begin
      if (s_q.open[b] && s_q.row[b] == REQ_ROW_IN)
      begin
        if (s_q.rcd[b] == '0 && room)
        begin
          s_d.cmd   = CMD_READ;
          s_d.addr  = ROW_W'(REQ_COL_IN);
          s_d.addr[AUTO_BIT] = REQ_AUTO_PRE_IN;
          s_d.taken = 1'b1;
          rd        = 1'b1;
          if (REQ_AUTO_PRE_IN)
          begin
            s_d.open[b] = 1'b0;
            s_d.rp[b]   = AP_LD;
          end
        end
      end
      else if (s_q.open[b])
      begin
        // One-word reads end within latency-minus-one, so a closing precharge never cuts data.
        s_d.cmd     = CMD_PRECHARGE;
        s_d.addr    = '0;
        s_d.open[b] = 1'b0;
        s_d.rp[b]   = RP_LD;
      end
      else if (s_q.rp[b] == '0 && s_q.rc[b] == '0 && s_q.rrd == '0)
      begin
        s_d.cmd     = CMD_ACTIVE;
        s_d.addr    = REQ_ROW_IN;
        s_d.open[b] = 1'b1;
        s_d.row[b]  = REQ_ROW_IN;
        s_d.rcd[b]  = RCD_LD;
        s_d.rc[b]   = RC_LD;
        s_d.rrd     = RRD_LD;
      end
    end
    s_d.fly   = {s_q.fly[READ_LATENCY-1:0], rd};
    // Sampled one edge after the word became valid, matching the device latency.
    arrive    = s_q.fly[READ_LATENCY];
    pop       = s_q.vld && RD_READY_IN;
    after_pop = s_q.cnt - 2'(pop);
    if (pop)
    begin
      s_d.buff[0] = s_q.buff[1];
    end
    if (arrive)
    begin
      s_d.buff[after_pop[0]] = lnk.dq;
    end
    s_d.cnt = after_pop + 2'(arrive);
    s_d.vld = (s_d.cnt != 2'h0);
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lnk.cmd        = s_q.cmd;
  assign lnk.bank       = s_q.bank;
  assign lnk.addr       = s_q.addr;
  assign lnk.mask       = s_q.mask;
  assign REQ_ACCEPT_OUT = s_q.taken;
  assign RD_VALID_OUT   = s_q.vld;
  assign RD_DATA_OUT    = s_q.buff[0];
endmodule

// [sdram_link_props.sv]
// Link checks between the controller and the DRAM end.
module sdram_link_props
  import sdram_pkg::*;
#(
  parameter int READ_LATENCY = 2
)
(
  input wire logic                          SYS_CLK_IN,
  input wire logic                          SYS_RST_IN,
  input wire sdram_pkg::cmd_t               cmd,
  input wire logic [sdram_pkg::BANK_W-1:0]  bank,
  input wire logic [sdram_pkg::ROW_W-1:0]   addr,
  input wire logic                          mask,
  input wire logic [sdram_pkg::DQ_W-1:0]    dq,
  input wire logic                          dq_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_pkg::*;
  localparam int LAT = READ_LATENCY;
  logic [3:0]       act_age [BANKS];
  logic [3:0]       pre_age [BANKS];
  logic [3:0]       any_age;
  logic [BANKS-1:0] open_q;
  logic [ROW_W-1:0] row_q [BANKS];
  logic [DQ_W-1:0]  exp_w;
  assign exp_w = {bank, row_q[bank][ROW_PAT_W-1:0], addr[COL_W-1:0]};
  // Ages saturate so that a long idle spell never wraps into a false spacing fault.
  always_ff @(posedge SYS_CLK_IN)
  begin
    any_age <= (SYS_RST_IN || any_age == 4'hf) ? 4'hf : any_age + 4'h1;
    if (!SYS_RST_IN && cmd == CMD_ACTIVE)
      any_age <= 4'h1;
    for (int b = 0; b < BANKS; b++)
    begin
      act_age[b] <= (SYS_RST_IN || act_age[b] == 4'hf) ? 4'hf : act_age[b] + 4'h1;
      pre_age[b] <= (SYS_RST_IN || pre_age[b] == 4'hf) ? 4'hf : pre_age[b] + 4'h1;
      if (SYS_RST_IN)
        open_q[b] <= 1'b0;
      else if (cmd == CMD_ACTIVE && bank == BANK_W'(b))
      begin
        act_age[b] <= 4'h1;
        open_q[b] <= 1'b1;
        row_q[b] <= addr;
      end
      else if ((cmd == CMD_PRECHARGE && (addr[AUTO_BIT] || bank == BANK_W'(b)))
               || (cmd == CMD_READ && addr[AUTO_BIT] && bank == BANK_W'(b)))
      begin
        open_q[b] <= 1'b0;
        pre_age[b] <= 4'h1;
      end
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_read_oe_start: assert property (cmd == CMD_READ |-> ##LAT dq_oe)
    else $error("data pins not driven after read latency");
  chk_read_word: assert property (cmd == CMD_READ |-> ##LAT dq == $past(exp_w, LAT))
    else $error("read word differs from bank, row and column");
  chk_oe_release: assert property (dq_oe |-> $past(cmd, LAT) == CMD_READ)
    else $error("data pins driven outside a burst");
  chk_col_open: assert property (cmd == CMD_READ |-> open_q[bank])
    else $error("read to a closed bank");
  chk_act_closed: assert property (cmd == CMD_ACTIVE |-> !open_q[bank] && act_age[bank] >= SAME_BANK_ACT_CYC)
    else $error("same bank activated too soon");
  chk_act_to_col: assert property (cmd == CMD_READ |-> act_age[bank] >= ACT_COL_DELAY_CYC)
    else $error("read before activate delay");
  chk_act_spacing: assert property (cmd == CMD_ACTIVE |-> any_age >= OTHER_BANK_ACT_CYC)
    else $error("activates too close together");
  chk_pre_period: assert property (cmd inside {CMD_ACTIVE, CMD_READ} |-> pre_age[bank] >= PRECHARGE_CYC)
    else $error("bank used during precharge");
  chk_no_write: assert property (cmd != CMD_WRITE && !mask)
    else $error("write or mask from a read-only controller");
  cover property (cmd == CMD_READ && addr[AUTO_BIT]);
  cover property (cmd == CMD_PRECHARGE);
  cover property (cmd == CMD_ACTIVE ##[1:30] cmd == CMD_ACTIVE);
endmodule

// [tb_top.sv]
// Controller and DRAM joined on one link, plus a second DRAM driven by the bench.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sdram_pkg::*;
  logic             SYS_CLK_IN = 1'b0;
  logic             SYS_RST_IN = 1'b1;
  logic             req_valid = 1'b0;
  logic [BANK_W-1:0] req_bank = '0;
  logic [ROW_W-1:0] req_row = '0;
  logic [COL_W-1:0] req_col = '0;
  logic             req_ap = 1'b0;
  logic             rd_ready = 1'b0;
  logic             req_accept, rd_valid, err_a, err_b;
  logic [DQ_W-1:0]  rd_data;
  logic [BANKS-1:0] open_b;
  logic [DQ_W-1:0]  exp_a [$];
  logic [DQ_W-1:0]  exp_b [$];
  logic [COL_W-1:0] cols [8] = '{9'h1fe, 9'h1ff, 9'h000, 9'h005, 9'h006, 9'h007, 9'h014, 9'h015};
  logic [31:0]      rs = 32'h0000dff2;
  logic [31:0]      rr;
  int               error_cnt = 0;
  int               cmp_count = 0;
  sdram_link_if lnk();
  sdram_link_if lnk_b();
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  sdram_controller #(.READ_LATENCY(2)) u_sdram_controller (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .REQ_VALID_IN(req_valid), .REQ_BANK_IN(req_bank), .REQ_ROW_IN(req_row), .REQ_COL_IN(req_col),
    .REQ_AUTO_PRE_IN(req_ap), .REQ_ACCEPT_OUT(req_accept), .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data),
    .RD_READY_IN(rd_ready), .lnk(lnk));
  sdram_device u_sdram_device (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .READ_LATENCY_IN(1'b0),
    .BURST_LENGTH_IN(BL_1), .BANK_OPEN_OUT(), .CMD_ERROR_OUT(err_a), .lnk(lnk));
  sdram_device u_sdram_device_b (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .READ_LATENCY_IN(1'b1),
    .BURST_LENGTH_IN(BL_PAGE), .BANK_OPEN_OUT(open_b), .CMD_ERROR_OUT(err_b), .lnk(lnk_b));
  sdram_link_props #(.READ_LATENCY(2)) u_sdram_link_props (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .cmd(lnk.cmd), .bank(lnk.bank), .addr(lnk.addr), .mask(lnk.mask), .dq(lnk.dq), .dq_oe(lnk.dq_oe));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic check(input string what, input logic [DQ_W-1:0] exp, input logic [DQ_W-1:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic issue(input cmd_t c, input logic [ROW_W-1:0] a, input logic m = 1'b0);
    @(posedge SYS_CLK_IN);
    lnk_b.cmd <= c;
    lnk_b.bank <= 2'h1;
    lnk_b.addr <= a;
    lnk_b.mask <= m;
  endtask
  // The refusal flag is a one-cycle pulse, so it is looked at just after the edge that raises it.
  task automatic issue_chk(input cmd_t c, input logic [ROW_W-1:0] a, input logic e);
    issue(c, a);
    issue(CMD_NOP, 12'h000);
    #1 check("refusal flag", {15'h0000, e}, {15'h0000, err_b});
  endtask
  always @(posedge SYS_CLK_IN)
  begin
    rr = rnd();
    rd_ready <= rr[20];
    if (!SYS_RST_IN && rd_valid && rd_ready)
      check("read data", exp_a.size() ? exp_a.pop_front() : 16'hxxxx, rd_data);
    if (lnk_b.dq_oe)
      check("page word", exp_b.size() ? exp_b.pop_front() : 16'hxxxx, lnk_b.dq);
    if (!SYS_RST_IN)
      check("link refusal", 16'h0000, {15'h0000, err_a});
  end
  initial
  begin
    int          n;
    logic [31:0] q;
    lnk_b.cmd = CMD_NOP;
    lnk_b.bank = '0;
    lnk_b.addr = '0;
    lnk_b.mask = 1'b0;
    repeat (6) @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b0;
    issue_chk(CMD_READ, 12'h000, 1'b1);
    issue_chk(CMD_ACTIVE, 12'h0a3, 1'b0);
    check("open banks", 16'h0002, {12'h000, open_b});
    issue_chk(CMD_ACTIVE, 12'h0a3, 1'b1);
    foreach (cols[i])
      exp_b.push_back({2'h1, 5'h03, cols[i]});
    issue(CMD_READ, 12'h1fe);
    repeat (2) issue(CMD_NOP, 12'h000);
    issue(CMD_READ, 12'h005);
    repeat (2) issue(CMD_NOP, 12'h000);
    issue(CMD_BURST_STOP, 12'h000);
    repeat (6) issue(CMD_NOP, 12'h000);
    issue(CMD_READ, 12'h014);
    repeat (2) issue(CMD_NOP, 12'h000);
    repeat (2) issue(CMD_NOP, 12'h000, 1'b1);
    issue_chk(CMD_WRITE, 12'h014, 1'b0);
    issue_chk(CMD_PRECHARGE, 12'h000, 1'b0);
    check("open banks", 16'h0000, {12'h000, open_b});
    check("page words left", 16'h0000, 16'(exp_b.size()));
    @(posedge SYS_CLK_IN);
    repeat (40)
    begin
      q = rnd();
      req_bank <= q[1:0];
      req_row <= {11'h000, q[2]};
      req_col <= q[11:3];
      req_ap <= q[12];
      req_valid <= 1'b1;
      exp_a.push_back({q[1:0], 4'h0, q[2], q[11:3]});
      n = 0;
      do @(posedge SYS_CLK_IN); while (!req_accept && ++n < 100);
      if (n >= 100)
      begin
        $display("CHECK FAILED request accept expected 1 seen 0");
        error_cnt++;
        conclude();
      end
    end
    req_valid <= 1'b0;
    n = 0;
    while (exp_a.size() > 0 && n < 200)
    begin
      @(posedge SYS_CLK_IN);
      n++;
    end
    check("words left", 16'h0000, 16'(exp_a.size()));
    conclude();
  end
endmodule
